// *** logic/pxc_map.svh ***
// Purpose: Constants for the pixel input capture and de-skew block
// Assumes: Included by bare name from design files
// Notes:   Offsets, field positions, reset values and counts only
//
// Summary of operation
// RULE1: Full width: 24 bits give red, green, blue
// RULE2: Primary edge: low half, green low, blue
// RULE3: Half mode high half: red, green high
// RULE4: Half dual edge: syncs on secondary edge
// RULE5: Controller never pairs full width with dual
// RULE6: Full width: syncs on edge opposite data
// RULE7: Edge select 0: data falling, syncs rising
// RULE8: Edge select 1: data rising, syncs falling
// RULE9: Half dual edge: capture on both edges
// RULE10: Syncs change one period after valid falls
// RULE11: Syncs settle one period before valid rises
// RULE12: Shift equals setting minus four steps
// RULE13: Shift moves capture clock, data untouched
// RULE14: Setting from pins or serial registers
// RULE15: De-skew disabled: setting ignored, zero shift
// RULE16: De-skew works in both input widths
// RULE17: Half single edge uses odd phase clock
// RULE18: Controller holds valid high during pixels
// RULE19: Multi-function pins are setting when allowed
// RULE20: Half pixel shown only when both captured
// RULE21: Setting unsigned: below four advances, above delays
`ifndef PXC_MAP_SVH
`define PXC_MAP_SVH

`define PXC_PIX_W         24
`define PXC_HALF_W        12
`define PXC_SET_W         3
`define PXC_SHIFT_W       4
`define PXC_SYNC_STAGES   3

// Full width field positions (low bit of each colour)
`define PXC_FULL_RED_LSB  16
`define PXC_FULL_GRN_LSB  8
`define PXC_FULL_BLU_LSB  0

// Half width field positions on the 12-bit bus
`define PXC_HI_RED_LSB    4
`define PXC_HI_GRN_LSB    0
`define PXC_LO_GRN_LSB    8
`define PXC_LO_BLU_LSB    0

`define PXC_DESKEW_CENTER 4'h4
`define PXC_STEP_PS       240

`define PXC_RGB_RST       24'h00_0000
`define PXC_SHIFT_RST     4'h0
`define PXC_CTL_RST       3'h0

`endif

// *** logic/pxc_pkg.sv ***
// Purpose: Types shared by the pixel capture design files
// Assumes: Constants come from pxc_map.svh
// Notes:   Types only, no numbers of their own
`include "pxc_map.svh"
package pxc_pkg;

  typedef logic [`PXC_PIX_W-1:0]   pxc_rgb_t;
  typedef logic [`PXC_SET_W-1:0]   pxc_set_t;
  typedef logic [`PXC_SHIFT_W-1:0] pxc_shift_t;

  typedef enum logic [1:0] {
    PXC_FULL,
    PXC_HALF_DUAL,
    PXC_HALF_TWOCLK
  } pxc_mode_e;

  typedef struct packed {
    logic     vsync;
    logic     hsync;
    logic     de;
    pxc_rgb_t data;
  } pxc_word_s;

endpackage : pxc_pkg

// *** logic/pxc_sync_if.sv ***
// Purpose: Carries a raw level and its synchronised copy
// Assumes: One writer of raw, one synchroniser driving stable
// Notes:   Used only between the capture top and its synchroniser
`timescale 1ns/10ps
interface pxc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport sync_side (input raw, output stable);
  modport user_side (output raw, input stable);
endinterface : pxc_sync_if

// *** logic/pxc_sync3.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: raw is asynchronous to clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/10ps
`include "pxc_map.svh"
module pxc_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,                    // Destination clock
  input wire logic rst_b,                  // Async reset, active low
  pxc_sync_if.sync_side sp                 // Raw in, stable out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= sp.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per bit, a change counts once the last two stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          q_r[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  assign sp.stable = q_r;
endmodule : pxc_sync3

// *** logic/pxc_capture.sv ***
// Purpose: Capture a parallel pixel bus, build 24-bit pixels, de-skew
// Assumes: Mode pins are quasi-static; pixel clock runs during frames
// Notes:   Link side on input_pixel_clock, results handed to clk
`timescale 1ns/10ps
`include "pxc_map.svh"
module pxc_capture (
  input  wire logic               clk,                 // System clock
  input  wire logic               rst_b,               // Async reset
  input  wire logic               input_pixel_clock,   // Pixel clock
  input  wire logic               odd_phase_clock,     // Second phase
  input  wire pxc_pkg::pxc_rgb_t  pix_data,            // Pixel bus
  input  wire logic               pixel_valid,         // Data valid
  input  wire logic               hsync_in,            // Line sync
  input  wire logic               vsync_in,            // Frame sync
  input  wire logic               bus_width_select,    // 1 = 24 bit
  input  wire logic               dual_edge_select,    // 1 = both edges
  input  wire logic               edge_select,         // 1 = rising
  input  wire logic               deskew_enable,       // De-skew on
  input  wire logic               address_pin_select,  // Pins as addr
  input  wire pxc_pkg::pxc_set_t  multi_func_in,       // Shared pins
  input  wire logic               deskew_src_serial,   // Use serial reg
  input  wire pxc_pkg::pxc_set_t  deskew_serial_setting, // Serial value
  output logic                    pix_strobe,          // New word pulse
  output pxc_pkg::pxc_rgb_t       pix_rgb,             // Pixel out
  output logic                    pix_de,              // Valid out
  output logic                    pix_hsync,           // Line sync out
  output logic                    pix_vsync,           // Frame sync out
  output pxc_pkg::pxc_shift_t     capture_shift,       // Signed steps
  output pxc_pkg::pxc_set_t       gp_ctl,              // General inputs
  output logic                    mode_unsupported     // Full plus dual
);
  import pxc_pkg::*;

  // ---------------- Link side: input_pixel_clock domain ----------------
  pxc_sync_if #(.W(3)) lmode_if ();
  assign lmode_if.raw = {bus_width_select, dual_edge_select, edge_select};

  pxc_sync3 #(.W(3)) u_lmode_sync (
    .clk   (input_pixel_clock),
    .rst_b (rst_b),
    .sp    (lmode_if)
  );

  logic      l_bws;
  logic      l_dse;
  logic      l_edg;
  pxc_mode_e l_mode;
  assign {l_bws, l_dse, l_edg} = lmode_if.stable;

  // Full width ignores dual edge, which the controller must not select
  always_comb begin
    if (l_bws) begin
      l_mode = PXC_FULL;                           // see RULE5
    end else if (l_dse) begin
      l_mode = PXC_HALF_DUAL;                      // see RULE9
    end else begin
      l_mode = PXC_HALF_TWOCLK;                    // see RULE17
    end
  end

  pxc_word_s bus_w;
  assign bus_w = '{vsync: vsync_in, hsync: hsync_in,
                   de: pixel_valid, data: pix_data};

  // Every bus line is caught on both edges; selection happens later,
  // so the clock itself carries any de-skew and data is never delayed
  pxc_word_s pos_r;
  pxc_word_s neg_r;
  pxc_word_s oddp_r;
  pxc_word_s oddn_r;

  always_ff @(posedge input_pixel_clock or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= '0;
    end else begin
      pos_r <= bus_w;                              // see RULE13
    end
  end

  always_ff @(negedge input_pixel_clock or negedge rst_b) begin
    if (!rst_b) begin
      neg_r <= '0;
    end else begin
      neg_r <= bus_w;                              // see RULE9
    end
  end

  // Odd latching edges in half mode without dual edge
  always_ff @(posedge odd_phase_clock or negedge rst_b) begin
    if (!rst_b) begin
      oddp_r <= '0;
    end else begin
      oddp_r <= bus_w;                             // see RULE17
    end
  end

  always_ff @(negedge odd_phase_clock or negedge rst_b) begin
    if (!rst_b) begin
      oddn_r <= '0;
    end else begin
      oddn_r <= bus_w;                             // see RULE17
    end
  end

  pxc_word_s prim_w;
  pxc_word_s sec_w;
  pxc_word_s low_w;
  pxc_word_s low_hold_r;
  pxc_word_s asm_w;

  // Primary edge follows edge_select; secondary is the other edge
  assign prim_w = l_edg ? pos_r : neg_r;           // see RULE7, RULE8

  // Secondary edge comes from the odd phase clock when it is in use
  always_comb begin
    case (l_mode)
      PXC_HALF_TWOCLK: begin
        sec_w = l_edg ? oddp_r : oddn_r;           // see RULE17
      end
      default: begin
        sec_w = l_edg ? neg_r : pos_r;             // see RULE4, RULE6
      end
    endcase
  end

  always_ff @(posedge input_pixel_clock or negedge rst_b) begin
    if (!rst_b) begin
      low_hold_r <= '0;
    end else begin
      low_hold_r <= prim_w;
    end
  end

  // A falling primary edge precedes the rising secondary by half a
  // clock, so its low half is held to pair with the next high half
  assign low_w = l_edg ? prim_w : low_hold_r;      // see RULE20

  pxc_word_s full_w;
  pxc_word_s half_w;

  // Full width: one whole pixel on the primary edge
  always_comb begin
    full_w = '0;
    full_w.data[`PXC_FULL_RED_LSB +: 8] =
      prim_w.data[`PXC_FULL_RED_LSB +: 8];         // see RULE1
    full_w.data[`PXC_FULL_GRN_LSB +: 8] =
      prim_w.data[`PXC_FULL_GRN_LSB +: 8];         // see RULE1
    full_w.data[`PXC_FULL_BLU_LSB +: 8] =
      prim_w.data[`PXC_FULL_BLU_LSB +: 8];         // see RULE1
    full_w.de    = prim_w.de;                      // see RULE7, RULE8
    full_w.hsync = sec_w.hsync;                    // see RULE6
    full_w.vsync = sec_w.vsync;                    // see RULE6
  end

  // Half width: high half from the secondary edge, low half paired
  always_comb begin
    half_w = '0;
    half_w.data[`PXC_FULL_RED_LSB +: 8] =
      sec_w.data[`PXC_HI_RED_LSB +: 8];            // see RULE3
    half_w.data[`PXC_FULL_GRN_LSB + 4 +: 4] =
      sec_w.data[`PXC_HI_GRN_LSB +: 4];            // see RULE3
    half_w.data[`PXC_FULL_GRN_LSB +: 4] =
      low_w.data[`PXC_LO_GRN_LSB +: 4];            // see RULE2
    half_w.data[`PXC_FULL_BLU_LSB +: 8] =
      low_w.data[`PXC_LO_BLU_LSB +: 8];            // see RULE2
    half_w.de    = low_w.de;                       // see RULE20
    half_w.hsync = sec_w.hsync;                    // see RULE4
    half_w.vsync = sec_w.vsync;                    // see RULE4
  end

  always_comb begin
    case (l_mode)
      PXC_FULL: asm_w = full_w;
      default:  asm_w = half_w;
    endcase
  end

  // Two slots alternate so a slot stays put for two pixel periods,
  // longer than the system side needs to notice and read it
  pxc_word_s slot_r [2];
  logic      tgl_r;
  logic      tgl_nxt;

  assign tgl_nxt = ~tgl_r;

  always_ff @(posedge input_pixel_clock or negedge rst_b) begin
    if (!rst_b) begin
      tgl_r <= 1'b0;
    end else begin
      tgl_r <= tgl_nxt;
    end
  end

  // Slot k takes the word whose toggle value after the edge is k
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_slot
      always_ff @(posedge input_pixel_clock or negedge rst_b) begin
        if (!rst_b) begin
          slot_r[k] <= '0;
        end else if (tgl_nxt == 1'(k)) begin
          slot_r[k] <= asm_w;
        end
      end
    end
  endgenerate

  // ---------------- System side: clk domain ----------------
  pxc_sync_if #(.W(1)) tgl_if ();
  assign tgl_if.raw = tgl_r;

  // Mode pins are resynchronised here too; the link-side copies belong
  // to the pixel clock, which may stand still
  pxc_sync_if #(.W(7)) cfg_if ();
  assign cfg_if.raw = {bus_width_select, dual_edge_select,
                       deskew_enable, address_pin_select, multi_func_in};

  pxc_sync3 #(.W(1)) u_tgl_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .sp    (tgl_if)
  );

  pxc_sync3 #(.W(7)) u_cfg_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .sp    (cfg_if)
  );

  logic     s_bws;
  logic     s_dse;
  logic     s_den;
  logic     s_aps;
  pxc_set_t s_mf;
  assign {s_bws, s_dse, s_den, s_aps, s_mf} = cfg_if.stable;

  logic tgl_seen_r;
  logic new_word;
  assign new_word = (tgl_if.stable != tgl_seen_r);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_seen_r <= tgl_if.stable;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pix_strobe <= 1'b0;
    end else begin
      pix_strobe <= new_word;
    end
  end

  // The slot named by the new toggle value was written last
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pix_rgb <= `PXC_RGB_RST;
    end else if (new_word) begin
      pix_rgb <= slot_r[tgl_if.stable].data;
    end
  end

  // Qualifiers move with the pixel so a reader sees one whole word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pix_de    <= 1'b0;
      pix_hsync <= 1'b0;
      pix_vsync <= 1'b0;
    end else if (new_word) begin
      pix_de    <= slot_r[tgl_if.stable].de;
      pix_hsync <= slot_r[tgl_if.stable].hsync;
      pix_vsync <= slot_r[tgl_if.stable].vsync;
    end
  end

  // De-skew setting source and signed shift toward the clock delay cell
  pxc_set_t   set_w;
  logic       set_ok;
  pxc_shift_t capture_shift_nxt;

  // Serial value wins; pin value only while the pins are not addresses
  always_comb begin
    set_w  = deskew_src_serial ? deskew_serial_setting : s_mf; // see RULE14
    set_ok = deskew_src_serial | ~s_aps;           // see RULE19
  end

  // Unsigned setting, so wraparound below four gives a negative count
  always_comb begin
    if (s_den && set_ok) begin
      capture_shift_nxt = {1'b0, set_w}
                        - `PXC_DESKEW_CENTER;      // see RULE12, RULE21
    end else begin
      capture_shift_nxt = `PXC_SHIFT_RST;          // see RULE15
    end
  end

  // Same shift whatever the width mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_shift <= `PXC_SHIFT_RST;
    end else begin
      capture_shift <= capture_shift_nxt;          // see RULE16
    end
  end

  // Shared pins are plain inputs only with both selects low
  pxc_set_t gp_ctl_nxt;

  assign gp_ctl_nxt = (!s_den && !s_aps) ? s_mf : `PXC_CTL_RST; // see RULE19

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gp_ctl <= `PXC_CTL_RST;
    end else begin
      gp_ctl <= gp_ctl_nxt;
    end
  end

  // Flags the pairing the controller must not select; system clock copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_unsupported <= 1'b0;
    end else begin
      mode_unsupported <= s_bws & s_dse;
    end
  end
endmodule : pxc_capture

// *** test/pxc_capture_sva.sv ***
// Purpose: Port-level checks of the pixel capture block
// Assumes: Config pins held for several clk cycles before judging
// Notes:   Seven-cycle windows cover the pin synchroniser delay
`timescale 1ns/10ps
module pxc_capture_chk
  import pxc_pkg::*;
(
  input wire logic     clk,                   // Clock
  input wire logic     rst_b,                 // Reset
  input wire logic     deskew_enable,         // De-skew on
  input wire logic     address_pin_select,    // Pins as addr
  input wire pxc_set_t multi_func_in,         // Shared pins
  input wire logic     deskew_src_serial,     // Serial source
  input wire pxc_set_t deskew_serial_setting, // Serial value
  input wire logic     pix_strobe,            // Word pulse
  input wire pxc_rgb_t pix_rgb,               // Pixel
  input wire logic     pix_de,                // Valid
  input wire pxc_shift_t capture_shift,       // Steps
  input wire pxc_set_t gp_ctl                 // General inputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_shift_off;
    !deskew_enable [*7] |-> capture_shift == 4'h0;
  endproperty
  a_shift_off: assert property (p_shift_off)
    else $error("shift not zero with de-skew off");
  property p_shift_pins;
    (deskew_enable && !address_pin_select && !deskew_src_serial
      && $stable(multi_func_in)) [*7]
      |-> capture_shift == {1'b0, multi_func_in} - 4'h4;
  endproperty
  a_shift_pins: assert property (p_shift_pins)
    else $error("shift does not follow pin setting");
  property p_shift_serial;
    (deskew_enable && deskew_src_serial
      && $stable(deskew_serial_setting)) [*7]
      |-> capture_shift == {1'b0, deskew_serial_setting} - 4'h4;
  endproperty
  a_shift_serial: assert property (p_shift_serial)
    else $error("shift does not follow serial setting");
  property p_shift_addr;
    (deskew_enable && address_pin_select && !deskew_src_serial) [*7]
      |-> capture_shift == 4'h0;
  endproperty
  a_shift_addr: assert property (p_shift_addr)
    else $error("address pins taken as setting");
  property p_gp_on;
    (!deskew_enable && !address_pin_select && $stable(multi_func_in))
      [*7] |-> gp_ctl == multi_func_in;
  endproperty
  a_gp_on: assert property (p_gp_on)
    else $error("general inputs not passed");
  property p_gp_off;
    deskew_enable [*7] |-> gp_ctl == 3'h0;
  endproperty
  a_gp_off: assert property (p_gp_off)
    else $error("general inputs shown while de-skew on");
  property p_strobe_gap;
    $rose(pix_strobe) |=> !pix_strobe [*2];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("words closer than one pixel period");
  property p_word_hold;
    !pix_strobe |-> $stable(pix_rgb) && $stable(pix_de);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("pixel word moved without strobe");
endmodule : pxc_capture_chk

bind pxc_capture pxc_capture_chk u_chk (.clk, .rst_b, .deskew_enable,
  .address_pin_select, .multi_func_in, .deskew_src_serial,
  .deskew_serial_setting, .pix_strobe, .pix_rgb, .pix_de,
  .capture_shift, .gp_ctl);

// *** test/pxc_ctrl_model.sv ***
// Purpose: Graphics controller model driving the pixel bus
// Assumes: Bench calls ph twice per 80 ns pixel period
// Notes:   Clock stands still between calls
`timescale 1ns/10ps
module pxc_ctrl_model (
  output logic              input_pixel_clock, // Pixel clock
  output logic              odd_phase_clock,   // Second phase
  output pxc_pkg::pxc_rgb_t pix_data,          // Pixel bus
  output logic              pixel_valid,       // Data valid
  output logic              hsync_in,          // Line sync
  output logic              vsync_in           // Frame sync
);
  import pxc_pkg::*;
  // Odd edges fall where the main clock rises
  assign odd_phase_clock = ~input_pixel_clock;
  initial begin
    input_pixel_clock = 1'b0;
    pix_data = 24'h00_0000;
    {pixel_valid, hsync_in, vsync_in} = 3'b000;
  end
  // Half period: drive, 20 ns setup, one edge, 20 ns hold
  task automatic ph(pxc_rgb_t d, logic de, logic [1:0] s);
    pix_data = d;
    {pixel_valid, hsync_in, vsync_in} = {de, s};
    #20;
    input_pixel_clock = ~input_pixel_clock;
    #20;
  endtask : ph
  // Extra 7 ns keeps link edges off the system clock edges
  task automatic set_clk(logic lvl);
    #27;
    input_pixel_clock = lvl;
    #20;
  endtask : set_clk
endmodule : pxc_ctrl_model

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the pixel capture block
// Assumes: Controller model drives the pixel side
// Notes:   Words with pix_de high are queued and compared in order
`timescale 1ns/10ps
module testbench;
  import pxc_pkg::*;
  logic       clk, rst_b, input_pixel_clock, odd_phase_clock;
  logic       pixel_valid, hsync_in, vsync_in, bus_width_select;
  logic       dual_edge_select, edge_select, deskew_enable;
  logic       address_pin_select, deskew_src_serial, pix_strobe;
  logic       pix_de, pix_hsync, pix_vsync, mode_unsupported;
  pxc_rgb_t   pix_data, pix_rgb;
  pxc_set_t   multi_func_in, deskew_serial_setting, gp_ctl;
  pxc_shift_t capture_shift;
  logic [25:0] got_q[$];
  int         error_cnt, cmp_count;

  pxc_ctrl_model mdl (.input_pixel_clock, .odd_phase_clock, .pix_data,
    .pixel_valid, .hsync_in, .vsync_in);
  pxc_capture dut (.clk, .rst_b, .input_pixel_clock, .odd_phase_clock,
    .pix_data, .pixel_valid, .hsync_in, .vsync_in, .bus_width_select,
    .dual_edge_select, .edge_select, .deskew_enable, .address_pin_select,
    .multi_func_in, .deskew_src_serial, .deskew_serial_setting,
    .pix_strobe, .pix_rgb, .pix_de, .pix_hsync, .pix_vsync,
    .capture_shift, .gp_ctl, .mode_unsupported);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (pix_strobe === 1'b1 && pix_de === 1'b1)
      got_q.push_back({pix_hsync, pix_vsync, pix_rgb});

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk_word(logic [25:0] got, logic [25:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(logic got, logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic chk_cfg(logic [6:0] got, logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: config %h not %h", $time, got, exp);
    end
  endtask : chk_cfg

  // Kind 0 full rising, 1 full falling, 2 half dual, 3 half two-clock,
  // 4 half dual with the low half on the rising edge
  // Off-edge data and syncs are inverted so a wrong edge shows
  task automatic send(int kind, logic de, logic [1:0] s, pxc_rgb_t p);
    if (kind == 0) begin
      mdl.ph(p, de, ~s);
      mdl.ph(~p, 1'b0, s);
    end else if (kind == 1) begin
      mdl.ph(~p, 1'b0, s);
      mdl.ph(p, de, ~s);
    end else begin
      mdl.ph({12'h000, p[11:0]}, de, ~s);
      mdl.ph({12'h000, p[23:12]}, 1'b0, s);
    end
  endtask : send

  task automatic frame(int kind, logic [1:0] s, pxc_rgb_t p0, p1);
    int n;
    @(negedge clk);
    bus_width_select = (kind < 2);
    dual_edge_select = (kind == 2 || kind == 4);
    edge_select = (kind == 0 || kind == 4);
    mdl.set_clk(kind == 2 || kind == 3);
    repeat (6) send(kind, 1'b0, s, 24'h00_0000);
    got_q.delete();
    send(kind, 1'b1, s, p0);
    send(kind, 1'b1, s, p1);
    repeat (4) send(kind, 1'b0, s, 24'h00_0000);
    n = 0;
    while (got_q.size() < 2 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (got_q.size() < 2) begin
      error_cnt++;
      $display("unexpected at %0t: pixel words missing", $time);
      complete_run();
    end else begin
      chk_word(got_q[0], {s, p0});
      chk_word(got_q[1], {s, p1});
    end
  endtask : frame

  task automatic test_full();
    frame(0, 2'b10, 24'hA5_3C96, 24'h5A_C369);
    frame(1, 2'b01, 24'h0F_F081, 24'hF0_0F7E);
  endtask : test_full

  task automatic test_half();
    frame(2, 2'b10, 24'hA5_3C96, 24'h5A_C369);
    frame(3, 2'b01, 24'h0F_F081, 24'hF0_0F7E);
    frame(4, 2'b11, 24'h3C_96A5, 24'hC3_695A);
  endtask : test_half

  // Pixel clock stands still here, so no words are built meanwhile
  task automatic test_mode();
    @(negedge clk);
    {bus_width_select, dual_edge_select} = 2'b11;
    repeat (8) @(negedge clk);
    chk_flag(mode_unsupported, 1'b1);
    {bus_width_select, dual_edge_select} = 2'b10;
    repeat (8) @(negedge clk);
    chk_flag(mode_unsupported, 1'b0);
  endtask : test_mode

  task automatic cfg(logic [2:0] ctl, pxc_set_t pins, ser);
    @(negedge clk);
    {deskew_enable, address_pin_select, deskew_src_serial} = ctl;
    multi_func_in = pins;
    deskew_serial_setting = ser;
    repeat (8) @(negedge clk);
  endtask : cfg

  // Runs with the half-width bus still selected
  task automatic test_deskew();
    for (int v = 0; v < 8; v++) begin
      cfg(3'b100, 3'(v), 3'h0);
      chk_cfg({capture_shift, gp_ctl}, {4'(v) - 4'h4, 3'h0});
    end
    cfg(3'b000, 3'h7, 3'h0);
    chk_cfg({capture_shift, gp_ctl}, {4'h0, 3'h7});
    cfg(3'b110, 3'h7, 3'h0);
    chk_cfg({capture_shift, gp_ctl}, {4'h0, 3'h0});
    cfg(3'b111, 3'h7, 3'h2);
    chk_cfg({capture_shift, gp_ctl}, {4'hE, 3'h0});
  endtask : test_deskew

  initial begin
    {rst_b, bus_width_select, dual_edge_select, edge_select} = 4'b0101;
    {deskew_enable, address_pin_select, deskew_src_serial} = 3'b000;
    multi_func_in = 3'h0;
    deskew_serial_setting = 3'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    test_full();
    test_half();
    test_deskew();
    test_mode();
    complete_run();
  end
endmodule : testbench
